// ===== hw/fbio_port.sv
// How it works
// - Output mode drives each I/O pin with its stored data bit.
// - Data register accepts writes in input mode too.
// - Reading port data returns sampled pin levels, not stored value.
// - Direction bit sets output when one; readable; resets to zero.
// - Direction bit does not affect serial or input-only pins.
// - Pull-up bit enables I/O-pin pull-ups when set; readable; resets zero.
// - Output mode forces I/O-pin pull-ups off.
// - Input-only pins keep pull-up on always.
// - Port interrupt mask bit enables interrupt; readable; resets zero.
// - Falling edge on selected input-only pin sets port flag while port mask is set.
// - Port flag clears on read; writes ignored.
// - Port flag is zero after reset.
// - Serial pin direction bit: one output, zero input; resets zero.
// - Serial interrupt mask bit enables serial interrupt; resets zero.
// - Key flag in bit zero, read-only, reset zero, clears on read.
// - Input interrupt raised only while port mask enables it.
// - Optional filter rejects short pulses, accepts lows of 1.5 cycles.
`timescale 1ns/1ns
module fbio_port #(
  parameter logic [1:0] PIN0_CFG  = 2'h0,
  parameter logic [1:0] PIN1_CFG  = 2'h0,
  parameter logic [1:0] PIN2_CFG  = 2'h0,
  parameter logic [1:0] PIN3_CFG  = 2'h1,
  parameter logic [3:0] IRQ_SRC   = 4'hA,
  parameter logic [3:0] FILTER_EN = 4'hF,
  parameter int         HALF_CYC  = fbio_pkg::SAMPLE_HALF_CYC
) (
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  input  wire logic [fbio_pkg::ADDR_W-1:0]  addr,
  input  wire logic [fbio_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output      logic [fbio_pkg::DATA_W-1:0]  rd_data,
  input  wire logic [fbio_pkg::PINS-1:0]    pin_in,
  output      logic [fbio_pkg::PINS-1:0]    pin_out,
  output      logic [fbio_pkg::PINS-1:0]    pin_oe,
  output      logic [fbio_pkg::PINS-1:0]    pin_pullup,
  input  wire logic                         key_irq_event,
  output      logic                         serial_pin_direction,
  output      logic                         serial_irq_mask_bit,
  output      logic                         port_irq_req
);
  import fbio_pkg::*;

  localparam logic [7:0] CFG_ALL = {PIN3_CFG, PIN2_CFG, PIN1_CFG, PIN0_CFG};

  logic [DATA_W-1:0] port_data;
  logic              port_direction_bit;
  logic              pullup_enable_bit;
  logic              port_irq_mask_bit;
  logic              port_irq_flag;
  logic              key_irq_flag;
  logic [PINS-1:0]   filt_prev;
  logic [PINS-1:0]   fall;
  logic              port_event;
  logic              flag_read;
  logic [DATA_W-1:0] next_rd_data;

  fbio_flt_if flt ();

  assign flt.raw = pin_in;

  fbio_noise_filter #(
    .HALF_CYC  (HALF_CYC),
    .FILTER_EN (FILTER_EN)
  ) u_filter (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .flt     (flt.filter)
  );

  // Per-pin drive and pull-up from terminal configuration
  generate
    for (genvar i = 0; i < PINS; i++) begin : g_pin
      localparam logic [1:0] CFG = CFG_ALL[2*i+1:2*i];
      if (CFG == FBIO_CFG_IO) begin : g_io
        assign pin_oe[i]     = port_direction_bit;
        assign pin_out[i]    = port_data[i];
        assign pin_pullup[i] = pullup_enable_bit & ~port_direction_bit;
      end else if (CFG == FBIO_CFG_INPUT) begin : g_in
        assign pin_oe[i]     = 1'b0;
        assign pin_out[i]    = 1'b0;
        assign pin_pullup[i] = 1'b1;
      end else begin : g_ser
        assign pin_oe[i]     = 1'b0;
        assign pin_out[i]    = 1'b0;
        assign pin_pullup[i] = 1'b0;
      end
      // Falling edge on an input-only interrupt source
      assign fall[i] = (CFG == FBIO_CFG_INPUT) && IRQ_SRC[i] && filt_prev[i] && !flt.filt[i];
    end
  endgenerate

  assign port_event = |fall;
  assign flag_read  = rd_en && (addr == OFS_FLAGS);
  assign port_irq_req = port_irq_flag & port_irq_mask_bit;

  // Previous filtered level for edge detection
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_prev <= 4'hF;
    end else begin
      filt_prev <= flt.filt;
    end
  end

  // Port data register, written in either mode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_data <= RST_PIN_DATA;
    end else if (wr_en && addr == OFS_PIN_DATA) begin
      port_data <= wr_data;
    end
  end

  // Direction and pull-up control
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_direction_bit <= RST_DIR;
      pullup_enable_bit  <= RST_PULLUP;
    end else if (wr_en && addr == OFS_PULL_DIR) begin
      port_direction_bit <= wr_data[BIT_DIR];
      pullup_enable_bit  <= wr_data[BIT_PULLUP];
    end
  end

  // Mask bits and serial direction
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_irq_mask_bit    <= RST_PORT_MSK;
      serial_pin_direction <= RST_SER_DIR;
      serial_irq_mask_bit  <= RST_SER_MASK;
    end else if (wr_en && addr == OFS_MASK_SDIR) begin
      port_irq_mask_bit    <= wr_data[BIT_PORT_MSK];
      serial_pin_direction <= wr_data[BIT_SER_DIR];
      serial_irq_mask_bit  <= wr_data[BIT_SER_MASK];
    end
  end

  // Flags: set wins over clear-on-read, writes ignored
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_irq_flag <= RST_FLAG;
      key_irq_flag  <= RST_FLAG;
    end else begin
      if (port_event && port_irq_mask_bit) begin
        port_irq_flag <= 1'b1;
      end else if (flag_read) begin
        port_irq_flag <= 1'b0;
      end
      if (key_irq_event) begin
        key_irq_flag <= 1'b1;
      end else if (flag_read) begin
        key_irq_flag <= 1'b0;
      end
    end
  end

  // Read mux
  always_comb begin
    next_rd_data = 4'h0;
    unique case (addr)
      OFS_MASK_SDIR: begin
        next_rd_data[BIT_PORT_MSK] = port_irq_mask_bit;
        next_rd_data[BIT_SER_DIR]  = serial_pin_direction;
        next_rd_data[BIT_SER_MASK] = serial_irq_mask_bit;
      end
      OFS_FLAGS: begin
        next_rd_data[BIT_PORT_FLG] = port_irq_flag;
        next_rd_data[BIT_KEY_FLAG] = key_irq_flag;
      end
      OFS_PIN_DATA: begin
        next_rd_data = pin_in;
      end
      OFS_PULL_DIR: begin
        next_rd_data[BIT_DIR]    = port_direction_bit;
        next_rd_data[BIT_PULLUP] = pullup_enable_bit;
      end
      default: begin
        next_rd_data = 4'h0;
      end
    endcase
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 4'h0;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
    end else begin
      rd_data <= 4'h0;
    end
  end
endmodule

// ===== pkg/fbio_pkg.sv
package fbio_pkg;
  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  localparam int PINS   = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_MASK_SDIR = 8'hE9;
  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'hED;
  localparam logic [ADDR_W-1:0] OFS_PIN_DATA  = 8'hF6;
  localparam logic [ADDR_W-1:0] OFS_PULL_DIR  = 8'hFC;

  // Field positions
  localparam int BIT_SER_MASK = 0;
  localparam int BIT_SER_DIR  = 1;
  localparam int BIT_PORT_MSK = 2;
  localparam int BIT_KEY_FLAG = 0;
  localparam int BIT_PORT_FLG = 1;
  localparam int BIT_DIR      = 0;
  localparam int BIT_PULLUP   = 1;

  // Values after reset
  localparam logic RST_DIR      = 1'b0;
  localparam logic RST_PULLUP   = 1'b0;
  localparam logic RST_PORT_MSK = 1'b0;
  localparam logic RST_SER_MASK = 1'b0;
  localparam logic RST_SER_DIR  = 1'b0;
  localparam logic RST_FLAG     = 1'b0;
  localparam logic [DATA_W-1:0] RST_PIN_DATA = 4'h0;

  // Per-pin terminal configuration codes
  typedef enum logic [1:0] {
    FBIO_CFG_IO     = 2'h0,
    FBIO_CFG_INPUT  = 2'h1,
    FBIO_CFG_SERIAL = 2'h3
  } fbio_cfg_t;

  // Noise filter sampling: half period of the sampling clock in ns
  localparam int SYS_PERIOD_NS   = 4;
  localparam int SAMPLE_HALF_NS  = 40;
  localparam int SAMPLE_HALF_CYC = (SAMPLE_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
endpackage

// ===== pkg/fbio_flt_if.sv
`timescale 1ns/1ns
interface fbio_flt_if;
  import fbio_pkg::*;
  logic [PINS-1:0] raw;
  logic [PINS-1:0] filt;
  modport port   (output raw, input filt);
  modport filter (input raw, output filt);
endinterface

// ===== hw/fbio_noise_filter.sv
`timescale 1ns/1ns
module fbio_noise_filter #(
  parameter int               HALF_CYC  = fbio_pkg::SAMPLE_HALF_CYC,
  parameter logic [3:0]       FILTER_EN = 4'hF
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  fbio_flt_if.filter flt
);
  import fbio_pkg::*;

  logic [15:0]     tick_cnt;
  logic            tick;
  logic [PINS-1:0] samp;
  logic [PINS-1:0] held;

  // Half-period sampling tick
  assign tick = (tick_cnt == 16'(HALF_CYC - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= 16'h0000;
    end else if (tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // Each pin on its own accepts a level once two half-cycle samples agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      samp <= 4'hF;
      held <= 4'hF;
    end else if (tick) begin
      samp <= flt.raw;
      held <= (flt.raw & ~(samp ^ flt.raw)) | (held & (samp ^ flt.raw));
    end
  end

  // Per pin: filtered or raw
  generate
    for (genvar i = 0; i < PINS; i++) begin : g_pin
      assign flt.filt[i] = FILTER_EN[i] ? held[i] : flt.raw[i];
    end
  endgenerate
endmodule

// ===== sim/fbio_pins_model.sv
`timescale 1ns/1ns
module fbio_pins_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] pin_pullup,
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_val,
  output      logic [3:0] pin_in
);
  logic [3:0] float_q = 4'h5;
  // Floating pins wander
  always @(posedge sys_clk) float_q <= ~float_q;
  // Board level at each pin
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_q[i];
    end
  end
endmodule

// ===== sim/fbio_port_assertions.sv
`timescale 1ns/1ns
module fbio_port_assertions
  import fbio_pkg::*;
#(
  parameter logic [1:0] PIN0_CFG = 2'h0,
  parameter logic [1:0] PIN1_CFG = 2'h0,
  parameter logic [1:0] PIN2_CFG = 2'h0,
  parameter logic [1:0] PIN3_CFG = 2'h1
) (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [7:0] addr,
  input wire logic [3:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [3:0] rd_data,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_pullup,
  input wire logic       key_irq_event,
  input wire logic       serial_pin_direction,
  input wire logic       serial_irq_mask_bit,
  input wire logic       port_irq_req
);
  // Pins under the direction bit, and pins fixed as inputs
  localparam logic [3:0] IO_MASK = {PIN3_CFG == FBIO_CFG_IO, PIN2_CFG == FBIO_CFG_IO,
                                    PIN1_CFG == FBIO_CFG_IO, PIN0_CFG == FBIO_CFG_IO};
  localparam logic [3:0] IN_MASK = {PIN3_CFG == FBIO_CFG_INPUT, PIN2_CFG == FBIO_CFG_INPUT,
                                    PIN1_CFG == FBIO_CFG_INPUT, PIN0_CFG == FBIO_CFG_INPUT};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_dir;
    wr_en && addr == OFS_PULL_DIR |=> pin_oe == (IO_MASK & {4{$past(wr_data[BIT_DIR])}});
  endproperty
  a_dir: assert property (p_dir) else $error("drive enable wrong");
  property p_out_pu;
    |pin_oe |-> (pin_pullup & IO_MASK) == 4'h0;
  endproperty
  a_out_pu: assert property (p_out_pu) else $error("pull-up in output mode");
  property p_in_pu;
    (pin_pullup & IN_MASK) == IN_MASK;
  endproperty
  a_in_pu: assert property (p_in_pu) else $error("input pin pull-up off");
  property p_pu_on;
    wr_en && addr == OFS_PULL_DIR && wr_data == 4'h2 |=> pin_pullup == (IO_MASK | IN_MASK);
  endproperty
  a_pu_on: assert property (p_pu_on) else $error("pull-ups not on");
  property p_out;
    wr_en && addr == OFS_PIN_DATA |=> (pin_out & IO_MASK) == ($past(wr_data) & IO_MASK);
  endproperty
  a_out: assert property (p_out) else $error("pin data wrong");
  property p_rd_pin;
    rd_en && addr == OFS_PIN_DATA |=> rd_data == $past(pin_in);
  endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("pin read wrong");
  property p_ser;
    wr_en && addr == OFS_MASK_SDIR |=> {serial_pin_direction, serial_irq_mask_bit} == $past(wr_data[1:0]);
  endproperty
  a_ser: assert property (p_ser) else $error("serial bits wrong");
  property p_req;
    rd_en && addr == OFS_FLAGS && port_irq_req |=> rd_data[BIT_PORT_FLG];
  endproperty
  a_req: assert property (p_req) else $error("request without flag");
  property p_idle;
    !$past(rd_en) |-> rd_data == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_fixed_oe;
    (pin_oe & ~IO_MASK) == 4'h0;
  endproperty
  a_fixed_oe: assert property (p_fixed_oe) else $error("serial or input pin driven");
  c_req: cover property ($rose(port_irq_req));
  c_flag: cover property (rd_en && addr == OFS_FLAGS ##1 rd_data[BIT_PORT_FLG]);
  c_out: cover property (pin_oe == IO_MASK);
endmodule
bind fbio_port fbio_port_assertions #(.PIN0_CFG(PIN0_CFG), .PIN1_CFG(PIN1_CFG), .PIN2_CFG(PIN2_CFG),
  .PIN3_CFG(PIN3_CFG)) fbio_port_assertions_inst (.sys_clk(sys_clk), .reset_n(reset_n),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .key_irq_event(key_irq_event),
  .serial_pin_direction(serial_pin_direction), .serial_irq_mask_bit(serial_irq_mask_bit),
  .port_irq_req(port_irq_req));

// ===== sim/fbio_port_tb.sv
`timescale 1ns/1ns
module fbio_port_tb;
  import fbio_pkg::*;
  logic       sys_clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, key = 0, sdir, smsk, irq;
  logic [7:0] addr = 8'h00;
  logic [3:0] wr_data = 4'h0, ext_en = 4'h0, ext_val = 4'h0, rd_data, pin_in, pin_out, pin_oe, pin_pu;
  int         fail_count = 0, n_compared = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  // Pin 0 is wired as a serial line, held low by the board
  fbio_port #(.PIN0_CFG(2'h3), .HALF_CYC(2)) fbio_port_inst (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu), .key_irq_event(key),
    .serial_pin_direction(sdir), .serial_irq_mask_bit(smsk), .port_irq_req(irq));
  fbio_pins_model fbio_pins_model_inst (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task chk(logic [3:0] seen, logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus write, one strobe cycle
  task wr(logic [7:0] a, logic [3:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  // Bus read, data in following cycle
  task rdc(logic [7:0] a, logic [3:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask
  // Low pulse of n cycles on the input-only pin
  task fall(int n);
    @(posedge sys_clk);
    ext_en[3] <= 1'b1;
    ext_val[3] <= 1'b0;
    repeat (n) @(posedge sys_clk);
    ext_en[3] <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    chk(pin_pu, 4'h8);
    reset_n <= 1'b1;
    rdc(OFS_MASK_SDIR, 4'h0);
    rdc(OFS_FLAGS, 4'h0);
    rdc(OFS_PULL_DIR, 4'h0);
    $display("reset test done");
    @(posedge sys_clk);
    ext_en <= 4'h7;
    ext_val <= 4'h2;
    wr(OFS_PIN_DATA, 4'h5);
    chk(pin_oe, 4'h0);
    rdc(OFS_PIN_DATA, 4'hA);
    @(posedge sys_clk);
    ext_en <= 4'h1;
    wr(OFS_PULL_DIR, 4'h1);
    chk(pin_oe, 4'h6);
    rdc(OFS_PIN_DATA, 4'hC);
    wr(OFS_PULL_DIR, 4'h3);
    chk(pin_pu, 4'h8);
    wr(OFS_PULL_DIR, 4'h2);
    chk(pin_pu, 4'hE);
    rdc(OFS_PULL_DIR, 4'h2);
    rdc(OFS_PIN_DATA, 4'hE);
    $display("pin test done");
    wr(OFS_MASK_SDIR, 4'h3);
    chk({2'h0, sdir, smsk}, 4'h3);
    fall(10);
    chk({3'h0, irq}, 4'h0);
    rdc(OFS_FLAGS, 4'h0);
    wr(OFS_MASK_SDIR, 4'h4);
    rdc(OFS_MASK_SDIR, 4'h4);
    fall(1);
    rdc(OFS_FLAGS, 4'h0);
    fall(6);
    chk({3'h0, irq}, 4'h1);
    wr(OFS_FLAGS, 4'h0);
    chk({3'h0, irq}, 4'h1);
    rdc(OFS_FLAGS, 4'h2);
    rdc(OFS_FLAGS, 4'h0);
    chk({3'h0, irq}, 4'h0);
    @(posedge sys_clk);
    key <= 1'b1;
    @(posedge sys_clk);
    key <= 1'b0;
    rdc(OFS_FLAGS, 4'h1);
    rdc(OFS_FLAGS, 4'h0);
    // Mid-run reset with a flag and the control bits set
    @(posedge sys_clk);
    key <= 1'b1;
    @(posedge sys_clk);
    key <= 1'b0;
    wr(OFS_PULL_DIR, 4'h3);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdc(OFS_FLAGS, 4'h0);
    rdc(OFS_PULL_DIR, 4'h0);
    chk(pin_oe, 4'h0);
    wr(8'h00, 4'hF);
    rdc(8'h00, 4'h0);
    $display("interrupt test done");
    end_of_test();
  end
endmodule
